// ===== include/lstk_pkg.sv
// constants and types shared by the lifo stack block
package lstk_pkg;

	localparam int          LSTK_WORD_W      = 4;
	localparam int          LSTK_ADDR_W      = 8;
	localparam int          LSTK_RAM_WORDS   = 256;
	localparam int          LSTK_UNUSED_LOCS = 2;
	localparam int          LSTK_DEPTH       = LSTK_RAM_WORDS - LSTK_UNUSED_LOCS;
	localparam int          LSTK_COUNT_W     = 9;
	localparam logic [7:0]  LSTK_ADDR_SEED   = 8'h01;

	// host-side limit on the stack clock, in MHz
	localparam int          LSTK_MAX_CLK_MHZ = 15;

	// register byte offsets
	localparam logic [4:0]  LSTK_OFS_CTRL    = 5'h00;
	localparam logic [4:0]  LSTK_OFS_STATUS  = 5'h04;
	localparam logic [4:0]  LSTK_OFS_COUNT   = 5'h08;
	localparam logic [4:0]  LSTK_OFS_IRQ_ST  = 5'h0c;
	localparam logic [4:0]  LSTK_OFS_IRQ_MSK = 5'h10;
	localparam logic [4:0]  LSTK_OFS_TOP     = 5'h14;

	// field positions and reset values
	localparam int          LSTK_CTRL_ENABLE = 0;
	localparam logic        LSTK_CTRL_RESET  = 1'b1;
	localparam int          LSTK_IRQ_W       = 6;
	localparam int          LSTK_IRQ_FULL    = 0;
	localparam int          LSTK_IRQ_AFULL   = 1;
	localparam int          LSTK_IRQ_EMPTY   = 2;
	localparam int          LSTK_IRQ_AEMPTY  = 3;
	localparam int          LSTK_IRQ_OVER    = 4;
	localparam int          LSTK_IRQ_UNDER   = 5;
	localparam logic [5:0]  LSTK_IRQ_MSK_RST = 6'h00;

	typedef enum logic [1:0] {
		LSTK_HOLD  = 2'b00,
		LSTK_WRITE = 2'b01,
		LSTK_READ  = 2'b10,
		LSTK_BOTH  = 2'b11
	} lstk_mode_t;

	typedef struct packed {
		logic full;
		logic almost_full;
		logic empty;
		logic almost_empty;
	} lstk_flags_t;

	typedef struct packed {
		logic       read;
		logic       write;
		logic [4:0] address;
		logic [31:0] writedata;
	} lstk_avs_req_t;

endpackage : lstk_pkg

// ===== src/lstk_top.sv
// lifo stack on 256x1 ram slices, with avalon-mm register slave and interrupt
//
// What this block does
// - each ram slice: 256 bits, 8-bit full decode
// - slice selected only: both low selects low, high high
// - selected with write enable low stores data in
// - selected with write enable high shows stored bit
// - slice output open collector, pull-up gives high
// - 4-bit words in; youngest unread word always out
// - full, almost full, empty, almost empty outputs
// - inputs sampled rising edge; host clock limit applies
// - write: in to output, output to pending, count up
// - pending word stored to ram in next cycle while still enabled
// - read: bus to output, pending held, count down
// - bus from pending after write, else from ram
// - read and write: load input, pending and counter kept
// - four modes decoded; hold changes nothing
// - almost flags one operation ahead of limits
// - address counter is reversible shift-register sequence
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps

module lstk_ram_bit
	import lstk_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   chip_select_low_a,
	input  wire logic                   chip_select_low_b,
	input  wire logic                   chip_select_high,
	input  wire logic                   write_enable_n,
	input  wire logic [LSTK_ADDR_W-1:0] ram_word_select,
	input  wire logic                   data_in,
	output logic                        data_out,
	output logic                        data_out_oe
);
	logic [LSTK_RAM_WORDS-1:0] cells;
	logic                      selected;
	logic                      wr_cell;
	logic                      rd_cell;

	// any select inactive leaves the cell array untouched and the line released
	assign selected = !chip_select_low_a && !chip_select_low_b && chip_select_high;
	assign wr_cell  = selected && !write_enable_n;
	assign rd_cell  = selected && write_enable_n;

	// the store happens at the edge that closes the write-enable cycle
	always_ff @(posedge clock) begin
		if (wr_cell) begin
			cells[ram_word_select] <= data_in;
		end
	end

	// the collector only ever sinks; a released line is pulled high outside
	assign data_out    = 1'b0;
	// a stored one leaves the line released, so the pull-up reads it back high
	assign data_out_oe = rd_cell && !cells[ram_word_select];

endmodule : lstk_ram_bit

module lstk_top
	import lstk_pkg::*;
#(
	parameter int DEPTH = LSTK_DEPTH
)
(
	input  wire logic                   clock,
	input  wire logic                   srst,
	input  wire logic [LSTK_WORD_W-1:0] stack_word_in,
	input  wire logic                   read_req,
	input  wire logic                   write_req,
	output logic      [LSTK_WORD_W-1:0] stack_word_out,
	output lstk_flags_t                 stack_flags,
	input  wire logic [4:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	output logic                        irq
);
	// occupancy thresholds; each almost flag sits one operation short of its limit
	localparam logic [LSTK_COUNT_W-1:0] FULL_AT  = LSTK_COUNT_W'(DEPTH);
	localparam logic [LSTK_COUNT_W-1:0] AFULL_AT = LSTK_COUNT_W'(DEPTH - 1);
	localparam logic [LSTK_COUNT_W-1:0] AEMPT_AT = LSTK_COUNT_W'(1);

	lstk_avs_req_t                  req;
	lstk_mode_t                     req_mode;
	lstk_mode_t                     mode;
	logic                           ctrl_enable;
	logic      [LSTK_WORD_W-1:0]    pend_word;
	logic                           wr_pending;
	logic      [LSTK_ADDR_W-1:0]    addr;
	logic      [LSTK_COUNT_W-1:0]   count;
	logic      [LSTK_WORD_W-1:0]    ram_bus;
	logic      [LSTK_WORD_W-1:0]    rd_bus;
	logic      [LSTK_WORD_W-1:0]    sink;
	lstk_flags_t                    flags_q;
	logic                           over_ev;
	logic                           under_ev;
	logic      [LSTK_IRQ_W-1:0]     events;
	logic      [LSTK_IRQ_W-1:0]     irq_status;
	logic      [LSTK_IRQ_W-1:0]     irq_mask;
	logic                           ack;
	logic                           wr_hit;
	logic      [31:0]               next_readdata;
	logic      [LSTK_IRQ_W-1:0]     clear_bits;
	logic                           status_wr;

	// both controls active high: read in the upper bit, write in the lower
	// bit, both high is the simultaneous read-and-write, both low is hold
	function automatic lstk_mode_t decode_mode(input logic rd, input logic wr);
		return lstk_mode_t'({rd, wr});
	endfunction : decode_mode

	// write into one register offset through byte lane 0
	function automatic logic reg_write(input logic       hit,
	                                   input logic       lane0,
	                                   input logic [4:0] a,
	                                   input logic [4:0] ofs);
		return hit && lane0 && (a == ofs);
	endfunction : reg_write

	// a flag that is set now and was clear one cycle ago
	function automatic logic rose(input logic now_v, input logic was_v);
		return now_v && !was_v;
	endfunction : rose

	// the all-zero state is never reached and the seed location is left
	// unwritten below the bottom word, so two of the 256 locations stay unused;
	// forward step of an 8-bit maximal shift-register sequence
	function automatic logic [7:0] addr_up(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : addr_up

	// exact inverse of addr_up
	function automatic logic [7:0] addr_down(input logic [7:0] s);
		return {s[0] ^ s[6] ^ s[5] ^ s[4], s[7:1]};
	endfunction : addr_down

	function automatic logic [31:0] mask_be(input logic [31:0] old_v,
	                                        input logic [31:0] new_v,
	                                        input logic [3:0]  be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : mask_be

	// bus request gathered into one carrier
	assign req = '{read:      avs_read,
	               write:     avs_write,
	               address:   avs_address,
	               writedata: avs_writedata};

	// mode decode; refused operations collapse to hold
	// a push into a full stack or a pop from an empty one would corrupt the
	// counter, so it changes nothing and is only reported as an event
	assign req_mode = decode_mode(read_req, write_req);
	always_comb begin
		mode     = req_mode;
		over_ev  = 1'b0;
		under_ev = 1'b0;
		if (!ctrl_enable) begin
			mode = LSTK_HOLD;
		end else if (req_mode == LSTK_WRITE && stack_flags.full) begin
			mode    = LSTK_HOLD;
			over_ev = 1'b1;
		end else if (req_mode == LSTK_READ && stack_flags.empty) begin
			mode     = LSTK_HOLD;
			under_ev = 1'b1;
		end
	end

	// ram slices, one per data bit; the wired-or line reads high when released
	// the two low selects are tied active and the enable drives the high one,
	// so a frozen stack also keeps its ram from storing a late pending word
	genvar gb;
	generate
		for (gb = 0; gb < LSTK_WORD_W; gb++) begin : g_slice
			lstk_ram_bit u_ram (
				.clock             (clock),
				.chip_select_low_a (1'b0),
				.chip_select_low_b (1'b0),
				.chip_select_high  (ctrl_enable),
				.write_enable_n    (!wr_pending),
				.ram_word_select   (addr),
				.data_in           (pend_word[gb]),
				.data_out          (),
				.data_out_oe       (sink[gb])
			);
			assign ram_bus[gb] = !sink[gb];
		end
	endgenerate

	assign rd_bus = wr_pending ? pend_word : ram_bus;

	// word order of the stack: the output register is the top and the ram at addr the word
	// beneath it, which the pending register holds until the ram has stored it;
	// a write pushes each one level down, a read pulls the next one up, so the
	// ram only ever sees the pending word, one cycle late
	always_ff @(posedge clock) begin
		if (srst) begin
			stack_word_out <= '0;
		end else begin
			case (mode)
				LSTK_WRITE: begin
					stack_word_out <= stack_word_in;
				end
				LSTK_BOTH: begin
					stack_word_out <= stack_word_in;
				end
				LSTK_READ: begin
					stack_word_out <= rd_bus;
				end
				default: begin
					stack_word_out <= stack_word_out;
				end
			endcase
		end
	end

	// ram write strobe: one cycle after each accepted write
	always_ff @(posedge clock) begin
		if (srst) begin
			wr_pending <= 1'b0;
		end else begin
			wr_pending <= (mode == LSTK_WRITE);
		end
	end

	// pending-write register: takes the old top on a write, else holds
	always_ff @(posedge clock) begin
		if (srst) begin
			pend_word <= '0;
		end else if (mode == LSTK_WRITE) begin
			pend_word <= stack_word_out;
		end
	end

	// address counter: steps forward on a write, back on a read
	always_ff @(posedge clock) begin
		if (srst) begin
			addr <= LSTK_ADDR_SEED;
		end else begin
			case (mode)
				LSTK_WRITE: addr <= addr_up(addr);
				LSTK_READ:  addr <= addr_down(addr);
				default:    addr <= addr;
			endcase
		end
	end

	// occupancy: accepted writes minus accepted reads
	always_ff @(posedge clock) begin
		if (srst) begin
			count <= '0;
		end else begin
			case (mode)
				LSTK_WRITE: count <= count + 1'b1;
				LSTK_READ:  count <= count - 1'b1;
				default:    count <= count;
			endcase
		end
	end

	// flags come straight from the registered count, so they follow the same
	// edge as the output register and never lag an operation
	assign stack_flags.full         = (count == FULL_AT);
	assign stack_flags.almost_full  = (count == AFULL_AT);
	assign stack_flags.empty        = (count == '0);
	assign stack_flags.almost_empty = (count == AEMPT_AT);

	// interrupt events: rising flags plus refused operations
	// empty starts high so that leaving reset raises no false empty event
	always_ff @(posedge clock) begin
		if (srst) begin
			flags_q <= '{full: 1'b0, almost_full: 1'b0, empty: 1'b1, almost_empty: 1'b0};
		end else begin
			flags_q <= stack_flags;
		end
	end

	always_comb begin
		events                  = '0;
		events[LSTK_IRQ_FULL]   = rose(stack_flags.full, flags_q.full);
		events[LSTK_IRQ_AFULL]  = rose(stack_flags.almost_full, flags_q.almost_full);
		events[LSTK_IRQ_EMPTY]  = rose(stack_flags.empty, flags_q.empty);
		events[LSTK_IRQ_AEMPTY] = rose(stack_flags.almost_empty, flags_q.almost_empty);
		events[LSTK_IRQ_OVER]   = over_ev;
		events[LSTK_IRQ_UNDER]  = under_ev;
	end

	// register slave: one wait cycle, answer on the second; a write lands on
	// the edge at which waitrequest is low, the same edge that ends the access
	assign avs_waitrequest = (req.read || req.write) && !ack;
	assign wr_hit          = req.write && ack;

	// ack is high in the answering cycle only, so back-to-back requests each wait
	always_ff @(posedge clock) begin
		if (srst) begin
			ack <= 1'b0;
		end else begin
			ack <= (req.read || req.write) && !ack;
		end
	end

	// enable: low freezes the stack and deselects the ram slices
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_enable <= LSTK_CTRL_RESET;
		end else if (reg_write(wr_hit, avs_byteenable[0], req.address, LSTK_OFS_CTRL)) begin
			ctrl_enable <= req.writedata[LSTK_CTRL_ENABLE];
		end
	end

	// interrupt mask, same layout as the status
	always_ff @(posedge clock) begin
		if (srst) begin
			irq_mask <= LSTK_IRQ_MSK_RST;
		end else if (reg_write(wr_hit, avs_byteenable[0], req.address, LSTK_OFS_IRQ_MSK)) begin
			irq_mask <= req.writedata[LSTK_IRQ_W-1:0];
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	assign status_wr  = reg_write(wr_hit, avs_byteenable[0], req.address, LSTK_OFS_IRQ_ST);
	assign clear_bits = status_wr ? req.writedata[LSTK_IRQ_W-1:0] : '0;

	always_ff @(posedge clock) begin
		if (srst) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~clear_bits) | events;
		end
	end

	assign irq = |(irq_status & irq_mask);

	// unmapped offsets read as zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		case (req.address)
			LSTK_OFS_CTRL:    next_readdata[LSTK_CTRL_ENABLE] = ctrl_enable;
			LSTK_OFS_STATUS:  next_readdata[3:0] = {stack_flags.full, stack_flags.almost_full,
			                                        stack_flags.empty, stack_flags.almost_empty};
			LSTK_OFS_COUNT:   next_readdata[LSTK_COUNT_W-1:0] = count;
			LSTK_OFS_IRQ_ST:  next_readdata[LSTK_IRQ_W-1:0] = irq_status;
			LSTK_OFS_IRQ_MSK: next_readdata[LSTK_IRQ_W-1:0] = irq_mask;
			LSTK_OFS_TOP:     next_readdata[LSTK_WORD_W-1:0] = stack_word_out;
			default:          next_readdata = 32'h0000_0000;
		endcase
	end

	// captured in the wait cycle; stands at the accepting edge and until the next read
	always_ff @(posedge clock) begin
		if (srst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (req.read && !ack) begin
			avs_readdata <= mask_be(32'h0000_0000, next_readdata, 4'hf);
		end
	end

endmodule : lstk_top

// ===== dv/lstk_assertions.sv
// port checker for the lifo stack
`timescale 1ns/1ps
module lstk_assertions
	import lstk_pkg::*;
#(
	parameter int DEPTH = LSTK_DEPTH
)
(
	input wire logic                   clock,
	input wire logic                   srst,
	input wire logic [LSTK_WORD_W-1:0] stack_word_in,
	input wire logic                   read_req,
	input wire logic                   write_req,
	input wire logic [LSTK_WORD_W-1:0] stack_word_out,
	input wire lstk_flags_t            stack_flags,
	input wire logic [4:0]             avs_address,
	input wire logic                   avs_read,
	input wire logic                   avs_write,
	input wire logic [31:0]            avs_writedata,
	input wire logic [3:0]             avs_byteenable,
	input wire logic [31:0]            avs_readdata,
	input wire logic                   avs_waitrequest,
	input wire logic                   irq
);
	wire wr_ok = write_req && !read_req && !stack_flags.full;
	wire rd_ok = read_req && !write_req && !stack_flags.empty;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	property p_hold;
		!read_req && !write_req |=> $stable(stack_word_out) && $stable(stack_flags);
	endproperty
	a_hold: assert property (p_hold) else $error("hold changed state");
	property p_wr;
		wr_ok |=> stack_word_out == $past(stack_word_in) && !stack_flags.empty;
	endproperty
	a_wr: assert property (p_wr) else $error("push did not load word");
	property p_both;
		read_req && write_req |=> stack_word_out == $past(stack_word_in) && $stable(stack_flags);
	endproperty
	a_both: assert property (p_both) else $error("push-pop wrong");
	property p_pend;
		wr_ok ##1 rd_ok |=> stack_word_out == $past(stack_word_out, 2);
	endproperty
	a_pend: assert property (p_pend) else $error("pop after push wrong");
	property p_afull;
		wr_ok && stack_flags.almost_full |=> stack_flags.full && !stack_flags.almost_full;
	endproperty
	a_afull: assert property (p_afull) else $error("almost full not ahead");
	property p_aempty;
		rd_ok && stack_flags.almost_empty |=> stack_flags.empty;
	endproperty
	a_aempty: assert property (p_aempty) else $error("almost empty not ahead");
	property p_refuse;
		write_req && !read_req && stack_flags.full |=> $stable(stack_word_out) && stack_flags.full;
	endproperty
	a_refuse: assert property (p_refuse) else $error("push when full changed");
	property p_excl;
		stack_flags.empty |-> !stack_flags.full && !stack_flags.almost_empty;
	endproperty
	a_excl: assert property (p_excl) else $error("flags contradict");
	c_full: cover property (stack_flags.full);
	c_both: cover property (read_req && write_req);
	c_pend: cover property (wr_ok ##1 rd_ok);
endmodule : lstk_assertions

bind lstk_top lstk_assertions #(.DEPTH(DEPTH)) i_lstk_assertions (.clock(clock), .srst(srst),
	.stack_word_in(stack_word_in), .read_req(read_req), .write_req(write_req),
	.stack_word_out(stack_word_out), .stack_flags(stack_flags), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq));

// ===== dv/lstk_host_model.sv
// host model driving the stack port
`timescale 1ns/1ps
module lstk_host_model
	import lstk_pkg::*;
(
	input  wire logic                   clock,
	input  wire lstk_flags_t            stack_flags,
	output logic      [LSTK_WORD_W-1:0] stack_word_in,
	output logic                        read_req,
	output logic                        write_req
);
	lstk_flags_t seen;
	initial begin
		stack_word_in = '0;
		read_req = 1'b0;
		write_req = 1'b0;
	end
	always @(negedge clock) begin
		seen <= stack_flags;
	end
	// one operation taken at the next edge; bad lets a refused one through
	task op(input logic rd, input logic wr, input logic [3:0] w, input logic last,
		input logic bad);
		logic keep;
		keep = bad || !((wr && !rd && seen.full) || (rd && !wr && seen.empty));
		read_req <= rd && keep;
		write_req <= wr && keep;
		stack_word_in <= w;
		@(posedge clock);
		if (last) begin
			read_req <= 1'b0;
			write_req <= 1'b0;
		end
	endtask : op
endmodule : lstk_host_model

// ===== dv/testbench.sv
// self-checking testbench for the lifo stack
`timescale 1ns/1ps
module testbench;
	import lstk_pkg::*;
	localparam int D = 6;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  stack_word_in;
	logic        read_req;
	logic        write_req;
	logic [3:0]  stack_word_out;
	lstk_flags_t stack_flags;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	int          fail_count = 0;
	int          checks_done = 0;
	always #5 clock = ~clock;
	lstk_top #(.DEPTH(D)) i_lstk_top (.clock(clock), .srst(srst), .stack_word_in(stack_word_in),
		.read_req(read_req), .write_req(write_req), .stack_word_out(stack_word_out),
		.stack_flags(stack_flags), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
	lstk_host_model i_lstk_host_model (.clock(clock), .stack_flags(stack_flags),
		.stack_word_in(stack_word_in), .read_req(read_req), .write_req(write_req));
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	function automatic logic [3:0] fexp(input int c);
		return {c == D, c == D - 1, c == 0, c == 1};
	endfunction : fexp
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task rd(input logic [4:0] a, input logic [31:0] exp, input string n);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(n, q, exp);
	endtask : rd
	task wrr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		#1;
	endtask : wrr
	task op1(input logic r, input logic w, input logic [3:0] x, input logic bad);
		@(posedge clock);
		i_lstk_host_model.op(r, w, x, 1'b1, bad);
		#1;
	endtask : op1
	task t_reset;
		chk("reset_flags", stack_flags, 4'b0010);
		chk("reset_out", stack_word_out, 32'h0);
		rd(5'h18, 32'h0, "unmapped");
	endtask : t_reset
	task t_lifo;
		@(posedge clock);
		i_lstk_host_model.op(1'b0, 1'b1, 4'h3, 1'b0, 1'b0);
		i_lstk_host_model.op(1'b0, 1'b1, 4'h5, 1'b0, 1'b0);
		i_lstk_host_model.op(1'b0, 1'b1, 4'h9, 1'b0, 1'b0);
		i_lstk_host_model.op(1'b1, 1'b0, 4'h0, 1'b0, 1'b0);
		i_lstk_host_model.op(1'b1, 1'b0, 4'h0, 1'b1, 1'b0);
		#1;
		chk("lifo_out", stack_word_out, 4'h3);
		chk("lifo_flags", stack_flags, fexp(1));
		op1(1'b1, 1'b0, 4'h0, 1'b0);
		chk("lifo_empty", stack_flags, fexp(0));
	endtask : t_lifo
	task t_fill;
		for (int i = 1; i <= D; i++) begin
			op1(1'b0, 1'b1, i[3:0], 1'b0);
			chk("fill_flags", stack_flags, fexp(i));
			chk("fill_out", stack_word_out, i[3:0]);
		end
		op1(1'b0, 1'b1, 4'hf, 1'b1);
		chk("over_out", stack_word_out, D);
		rd(LSTK_OFS_COUNT, D, "count");
		for (int i = D - 1; i >= 0; i--) begin
			op1(1'b1, 1'b0, 4'h0, 1'b0);
			chk("pop_flags", stack_flags, fexp(i));
			if (i > 0)
				chk("pop_out", stack_word_out, i);
		end
		op1(1'b1, 1'b0, 4'h0, 1'b1);
		chk("under_flags", stack_flags, fexp(0));
	endtask : t_fill
	task t_both;
		@(posedge clock);
		i_lstk_host_model.op(1'b0, 1'b1, 4'h7, 1'b0, 1'b0);
		i_lstk_host_model.op(1'b1, 1'b1, 4'h4, 1'b1, 1'b0);
		#1;
		chk("both_out", stack_word_out, 4'h4);
		chk("both_flags", stack_flags, fexp(1));
		repeat (3) @(posedge clock);
		#1;
		chk("hold_out", stack_word_out, 4'h4);
		rd(LSTK_OFS_COUNT, 32'h1, "both_count");
		rd(LSTK_OFS_TOP, 32'h4, "both_top");
		rd(LSTK_OFS_STATUS, {28'h0, fexp(1)}, "both_status");
		op1(1'b1, 1'b0, 4'h0, 1'b0);
		chk("both_pop", stack_flags, fexp(0));
	endtask : t_both
	task t_irq;
		rd(LSTK_OFS_IRQ_ST, 32'h3f, "irq_status");
		chk("irq_masked", irq, 1'b0);
		wrr(LSTK_OFS_IRQ_MSK, 32'h10);
		chk("irq_on", irq, 1'b1);
		wrr(LSTK_OFS_IRQ_ST, 32'h10);
		chk("irq_clear", irq, 1'b0);
		rd(LSTK_OFS_IRQ_ST, 32'h2f, "irq_left");
	endtask : t_irq
	initial begin
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1;
		t_reset();
		t_lifo();
		t_fill();
		t_both();
		t_irq();
		finish_test();
	end
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
endmodule : testbench
